//--- rtl/uhpsrc_pkg.sv
package uhpsrc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] UHPSRC_OFS_CFG_BYTE3 = 8'h08;
  localparam logic [7:0] UHPSRC_OFS_SWAP_MASK = 8'hFA;
  localparam logic [7:0] UHPSRC_OFS_MAP_PAIR1 = 8'hFB;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int UHPSRC_REMAP_EN_BIT = 3;
  localparam int UHPSRC_UPSTREAM_BIT = 0;
  localparam int UHPSRC_PHYS1_LSB = 0;
  localparam int UHPSRC_PHYS2_LSB = 4;
  localparam int UHPSRC_NIB_RSVD_BIT = 3;
  localparam logic [7:0] UHPSRC_SWAP_RESET = 8'h00;
  localparam logic [7:0] UHPSRC_MAP_RESET = 8'h00;
  localparam logic UHPSRC_REMAP_EN_RESET = 1'b0;

  // ---------------------------------------------------------------
  // Port numbering
  // ---------------------------------------------------------------
  localparam int UHPSRC_NUM_PINS = 8;
  localparam logic [2:0] UHPSRC_LOG_DISABLED = 3'h0;
  localparam logic [2:0] UHPSRC_PHYS1_ID = 3'h1;
  localparam logic [2:0] UHPSRC_PHYS2_ID = 3'h2;
  localparam logic [2:0] UHPSRC_DS_PORTS = 3'h7;
endpackage : uhpsrc_pkg

//--- rtl/uhpsrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module uhpsrc_top
  import uhpsrc_pkg::*;
#(
  parameter int NPINS = UHPSRC_NUM_PINS
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  // Configuration loader port
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic [7:0] CFG_WDATA_IN,
  input wire logic CFG_WR_IN,
  input wire logic CFG_RD_IN,
  input wire logic CFG_DONE_IN,
  output logic [7:0] CFG_RDATA_OUT,
  output logic CFG_RVALID_OUT,
  output logic CFG_LOCKED_OUT,
  // Core side, index 0 upstream, 1..7 downstream
  input wire logic [NPINS-1:0] CORE_POS_TX_IN,
  input wire logic [NPINS-1:0] CORE_POS_OE_IN,
  input wire logic [NPINS-1:0] CORE_NEG_TX_IN,
  input wire logic [NPINS-1:0] CORE_NEG_OE_IN,
  output logic [NPINS-1:0] CORE_POS_RX_OUT,
  output logic [NPINS-1:0] CORE_NEG_RX_OUT,
  // Data pins
  input wire logic [NPINS-1:0] POSITIVE_NAMED_PIN_IN,
  output logic [NPINS-1:0] POSITIVE_NAMED_PIN_OUT,
  output logic [NPINS-1:0] POSITIVE_NAMED_PIN_OE_OUT,
  input wire logic [NPINS-1:0] NEGATIVE_NAMED_PIN_IN,
  output logic [NPINS-1:0] NEGATIVE_NAMED_PIN_OUT,
  output logic [NPINS-1:0] NEGATIVE_NAMED_PIN_OE_OUT,
  // Port numbering
  output logic [2:0] PHYS1_LOGICAL_OUT,
  output logic [2:0] PHYS2_LOGICAL_OUT,
  output logic [2:0] DS_PORT_COUNT_OUT
);

  // ---------------------------------------------------------------
  // Remap nibble decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] map_decode(input logic [3:0] nib);
    if (nib[UHPSRC_NIB_RSVD_BIT]) begin
      map_decode = UHPSRC_LOG_DISABLED;
    end else begin
      map_decode = nib[2:0];
    end
  endfunction : map_decode

  logic [7:0] data_pin_swap_mask_reg;
  logic [7:0] port_map_first_pair_reg;
  logic remap_mode_enable_reg;
  logic locked_reg;
  logic [NPINS-1:0] pos_sync1_reg;
  logic [NPINS-1:0] pos_sync2_reg;
  logic [NPINS-1:0] neg_sync1_reg;
  logic [NPINS-1:0] neg_sync2_reg;
  logic [2:0] phys1_next;
  logic [2:0] phys2_next;
  logic [2:0] count_next;
  logic [7:0] rdata_next;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Sticky until reset; a write in the done cycle still lands
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      locked_reg <= 1'b0;
    end else if (CFG_DONE_IN) begin
      locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      data_pin_swap_mask_reg <= UHPSRC_SWAP_RESET;
      port_map_first_pair_reg <= UHPSRC_MAP_RESET;
      remap_mode_enable_reg <= UHPSRC_REMAP_EN_RESET;
    end else if (CFG_WR_IN && !locked_reg) begin
      if (CFG_ADDR_IN == UHPSRC_OFS_SWAP_MASK) begin
        data_pin_swap_mask_reg <= CFG_WDATA_IN;
      end
      if (CFG_ADDR_IN == UHPSRC_OFS_MAP_PAIR1) begin
        port_map_first_pair_reg <= CFG_WDATA_IN;
      end
      if (CFG_ADDR_IN == UHPSRC_OFS_CFG_BYTE3) begin
        remap_mode_enable_reg <= CFG_WDATA_IN[UHPSRC_REMAP_EN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read-back path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (CFG_ADDR_IN == UHPSRC_OFS_SWAP_MASK) begin
      rdata_next = data_pin_swap_mask_reg;
    end else if (CFG_ADDR_IN == UHPSRC_OFS_MAP_PAIR1) begin
      rdata_next = port_map_first_pair_reg;
    end else if (CFG_ADDR_IN == UHPSRC_OFS_CFG_BYTE3) begin
      rdata_next[UHPSRC_REMAP_EN_BIT] = remap_mode_enable_reg;
    end
  end

  // Read data is zero outside its valid cycle
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CFG_RDATA_OUT <= 8'h00;
      CFG_RVALID_OUT <= 1'b0;
      CFG_LOCKED_OUT <= 1'b0;
    end else begin
      CFG_RDATA_OUT <= CFG_RD_IN ? rdata_next : 8'h00;
      CFG_RVALID_OUT <= CFG_RD_IN;
      CFG_LOCKED_OUT <= locked_reg;
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  // Only the second stage feeds the swap logic
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pos_sync1_reg <= '0;
      pos_sync2_reg <= '0;
      neg_sync1_reg <= '0;
      neg_sync2_reg <= '0;
    end else begin
      pos_sync1_reg <= POSITIVE_NAMED_PIN_IN;
      pos_sync2_reg <= pos_sync1_reg;
      neg_sync1_reg <= NEGATIVE_NAMED_PIN_IN;
      neg_sync2_reg <= neg_sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Per-port pin role swap (index 0 upstream, others downstream)
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_swap
      // Drive enables travel with their data roles
      always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          POSITIVE_NAMED_PIN_OUT[g] <= 1'b0;
          POSITIVE_NAMED_PIN_OE_OUT[g] <= 1'b0;
          NEGATIVE_NAMED_PIN_OUT[g] <= 1'b0;
          NEGATIVE_NAMED_PIN_OE_OUT[g] <= 1'b0;
          CORE_POS_RX_OUT[g] <= 1'b0;
          CORE_NEG_RX_OUT[g] <= 1'b0;
        end else if (data_pin_swap_mask_reg[g]) begin
          POSITIVE_NAMED_PIN_OUT[g] <= CORE_NEG_TX_IN[g];
          POSITIVE_NAMED_PIN_OE_OUT[g] <= CORE_NEG_OE_IN[g];
          NEGATIVE_NAMED_PIN_OUT[g] <= CORE_POS_TX_IN[g];
          NEGATIVE_NAMED_PIN_OE_OUT[g] <= CORE_POS_OE_IN[g];
          CORE_POS_RX_OUT[g] <= neg_sync2_reg[g];
          CORE_NEG_RX_OUT[g] <= pos_sync2_reg[g];
        end else begin
          POSITIVE_NAMED_PIN_OUT[g] <= CORE_POS_TX_IN[g];
          POSITIVE_NAMED_PIN_OE_OUT[g] <= CORE_POS_OE_IN[g];
          NEGATIVE_NAMED_PIN_OUT[g] <= CORE_NEG_TX_IN[g];
          NEGATIVE_NAMED_PIN_OE_OUT[g] <= CORE_NEG_OE_IN[g];
          CORE_POS_RX_OUT[g] <= pos_sync2_reg[g];
          CORE_NEG_RX_OUT[g] <= neg_sync2_reg[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Physical-to-logical numbering and reported port count
  // ---------------------------------------------------------------
  always_comb begin
    if (remap_mode_enable_reg) begin
      phys1_next = map_decode(port_map_first_pair_reg[UHPSRC_PHYS1_LSB +: 4]);
      phys2_next = map_decode(port_map_first_pair_reg[UHPSRC_PHYS2_LSB +: 4]);
    end else begin
      phys1_next = UHPSRC_PHYS1_ID;
      phys2_next = UHPSRC_PHYS2_ID;
    end
    // Seven downstream ports, less one for each physical port whose logical number is 0
    count_next = UHPSRC_DS_PORTS;
    if (phys1_next == UHPSRC_LOG_DISABLED) begin
      count_next = count_next - 3'h1;
    end
    if (phys2_next == UHPSRC_LOG_DISABLED) begin
      count_next = count_next - 3'h1;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PHYS1_LOGICAL_OUT <= UHPSRC_PHYS1_ID;
      PHYS2_LOGICAL_OUT <= UHPSRC_PHYS2_ID;
      DS_PORT_COUNT_OUT <= UHPSRC_DS_PORTS;
    end else begin
      PHYS1_LOGICAL_OUT <= phys1_next;
      PHYS2_LOGICAL_OUT <= phys2_next;
      DS_PORT_COUNT_OUT <= count_next;
    end
  end

endmodule : uhpsrc_top
`default_nettype wire

//--- tb/tb_usb_hub_port_swap_remap_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_usb_hub_port_swap_remap_config;
  import uhpsrc_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, wr, rd, done, locked, rv;
  logic [7:0] addr, wdata, rdata, r, po, no, prx, tp = 8'hFF, tn = 8'h00, pp = 8'hFF, pn = 8'h00;
  logic [7:0] poe, noe, nrx, oep = 8'hF0, oen = 8'h0F;
  logic [2:0] p1, p2, cnt;
  int num_errors = 0, check_count = 0;
  always #10 clk = ~clk;
  uhpsrc_loader ldr (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rv), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .done_out(done));
  uhpsrc_top dut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .CFG_ADDR_IN(addr), .CFG_WDATA_IN(wdata),
    .CFG_WR_IN(wr), .CFG_RD_IN(rd), .CFG_DONE_IN(done), .CFG_RDATA_OUT(rdata),
    .CFG_RVALID_OUT(rv), .CFG_LOCKED_OUT(locked), .CORE_POS_TX_IN(tp), .CORE_POS_OE_IN(oep),
    .CORE_NEG_TX_IN(tn), .CORE_NEG_OE_IN(oen), .CORE_POS_RX_OUT(prx), .CORE_NEG_RX_OUT(nrx),
    .POSITIVE_NAMED_PIN_IN(pp), .POSITIVE_NAMED_PIN_OUT(po), .POSITIVE_NAMED_PIN_OE_OUT(poe),
    .NEGATIVE_NAMED_PIN_IN(pn), .NEGATIVE_NAMED_PIN_OUT(no), .NEGATIVE_NAMED_PIN_OE_OUT(noe),
    .PHYS1_LOGICAL_OUT(p1), .PHYS2_LOGICAL_OUT(p2), .DS_PORT_COUNT_OUT(cnt));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic t_swap;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      ldr.wr(UHPSRC_OFS_SWAP_MASK, m);
      repeat (4) @(posedge clk);
      #1 chk(po, ~m);
      chk(no, m);
      chk(prx, ~m);
      chk(nrx, m);
      chk(poe, oep ^ m);
      chk(noe, oen ^ m);
    end
  endtask : t_swap
  task automatic t_remap;
    logic [7:0] e1, e2;
    ldr.wr(UHPSRC_OFS_CFG_BYTE3, 8'hFF);
    ldr.rd(UHPSRC_OFS_CFG_BYTE3, r);
    chk(r, 8'h08);
    for (int v = 0; v < 16; v++) begin
      e1 = (v < 8) ? 8'(v) : 8'h00;
      e2 = (v >= 8) ? 8'(15 - v) : 8'h00;
      ldr.wr(UHPSRC_OFS_MAP_PAIR1, {4'(15 - v), 4'(v)});
      @(posedge clk);
      #1 chk({5'h0, p1}, e1);
      chk({5'h0, p2}, e2);
      chk({5'h0, cnt}, 8'(7 - int'(e1 == 8'h00) - int'(e2 == 8'h00)));
    end
    ldr.wr(UHPSRC_OFS_CFG_BYTE3, 8'h00);
    @(posedge clk);
    #1 chk({2'h0, p2, p1}, 8'h11);
    ldr.rd(8'h10, r);
    chk(r, 8'h00);
  endtask : t_remap
  task automatic t_lock;
    ldr.wr(UHPSRC_OFS_CFG_BYTE3, 8'h08);
    ldr.wr(UHPSRC_OFS_MAP_PAIR1, 8'h12);
    ldr.done();
    ldr.wr(UHPSRC_OFS_MAP_PAIR1, 8'h00);
    ldr.wr(UHPSRC_OFS_CFG_BYTE3, 8'h00);
    ldr.rd(UHPSRC_OFS_MAP_PAIR1, r);
    chk(r, 8'h12);
    chk({2'h0, p2, p1}, 8'h0A);
    chk({7'h0, locked}, 8'h01);
  endtask : t_lock
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk({2'h0, p2, p1}, 8'h11);
    chk({5'h0, cnt}, 8'h07);
    ldr.rd(UHPSRC_OFS_SWAP_MASK, r);
    chk(r, UHPSRC_SWAP_RESET);
    t_swap();
    t_remap();
    t_lock();
    complete_run();
  end
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule : tb_usb_hub_port_swap_remap_config
`default_nettype wire

//--- tb/uhpsrc_loader.sv
`timescale 1ns/1ps
`default_nettype none
module uhpsrc_loader (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic done_out
);
  initial begin
    {addr_out, wdata_out, wr_out, rd_out, done_out} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    // Data is taken at the edge where the valid pulse is sampled
    @(posedge clk_in);
    d = rvalid_in ? rdata_in : 8'hXX;
  endtask : rd
  task automatic done;
    @(posedge clk_in);
    done_out <= 1'b1;
    @(posedge clk_in);
    done_out <= 1'b0;
  endtask : done
endmodule : uhpsrc_loader
`default_nettype wire

//--- tb/uhpsrc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module uhpsrc_sva_chk
  import uhpsrc_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic CFG_RD_IN,
  input wire logic CFG_DONE_IN,
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic [7:0] CFG_RDATA_OUT,
  input wire logic CFG_RVALID_OUT,
  input wire logic CFG_LOCKED_OUT,
  input wire logic [NPINS-1:0] CORE_POS_TX_IN,
  input wire logic [NPINS-1:0] CORE_NEG_TX_IN,
  input wire logic [NPINS-1:0] CORE_POS_RX_OUT,
  input wire logic [NPINS-1:0] POSITIVE_NAMED_PIN_IN,
  input wire logic [NPINS-1:0] NEGATIVE_NAMED_PIN_IN,
  input wire logic [NPINS-1:0] POSITIVE_NAMED_PIN_OUT,
  input wire logic [NPINS-1:0] NEGATIVE_NAMED_PIN_OUT,
  input wire logic [2:0] PHYS1_LOGICAL_OUT,
  input wire logic [2:0] PHYS2_LOGICAL_OUT,
  input wire logic [2:0] DS_PORT_COUNT_OUT
);
  logic [1:0] up_reg;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Edges seen since reset release, so history never reaches back into reset
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  sequence s_lock;
    ##[1:2] CFG_LOCKED_OUT;
  endsequence
  sequence s_frozen;
    CFG_LOCKED_OUT && $past(CFG_LOCKED_OUT);
  endsequence
  AST_PIN_ROLE: assert property (up_reg != 2'h0 |->
    &((~(POSITIVE_NAMED_PIN_OUT ^ $past(CORE_POS_TX_IN)) & ~(NEGATIVE_NAMED_PIN_OUT ^ $past(CORE_NEG_TX_IN)))
    | (~(POSITIVE_NAMED_PIN_OUT ^ $past(CORE_NEG_TX_IN)) & ~(NEGATIVE_NAMED_PIN_OUT ^ $past(CORE_POS_TX_IN)))))
    else $error("pin drive is neither direct nor swapped");
  AST_RX_ROLE: assert property (up_reg == 2'h3 |-> &(~(CORE_POS_RX_OUT ^
    $past(POSITIVE_NAMED_PIN_IN, 3)) | ~(CORE_POS_RX_OUT ^ $past(NEGATIVE_NAMED_PIN_IN, 3))))
    else $error("received level from neither pin");
  AST_COUNT: assert property (DS_PORT_COUNT_OUT + 3'(PHYS1_LOGICAL_OUT == UHPSRC_LOG_DISABLED)
    + 3'(PHYS2_LOGICAL_OUT == UHPSRC_LOG_DISABLED) == UHPSRC_DS_PORTS)
    else $error("port count mismatch");
  AST_LOCK_SEQ: assert property (CFG_DONE_IN |-> s_lock) else $error("lock late");
  AST_LOCK_HOLD: assert property (CFG_LOCKED_OUT |=> CFG_LOCKED_OUT) else $error("unlock");
  AST_FROZEN: assert property (s_frozen |-> $stable(PHYS1_LOGICAL_OUT)
    && $stable(PHYS2_LOGICAL_OUT)) else $error("map changed while locked");
  AST_CFG_BYTE: assert property (CFG_RD_IN && CFG_ADDR_IN == UHPSRC_OFS_CFG_BYTE3 |=>
    CFG_RVALID_OUT && (CFG_RDATA_OUT & 8'hF7) == 8'h00) else $error("config byte read");
  AST_IDLE_DATA: assert property (!CFG_RVALID_OUT |-> CFG_RDATA_OUT == 8'h00)
    else $error("read data outside valid");
endmodule : uhpsrc_sva_chk
bind uhpsrc_top uhpsrc_sva_chk #(.NPINS(NPINS)) u_chk (.CLOCK_IN, .ARST_N_IN, .CFG_RD_IN,
  .CFG_DONE_IN, .CFG_ADDR_IN, .CFG_RDATA_OUT, .CFG_RVALID_OUT, .CFG_LOCKED_OUT, .CORE_POS_TX_IN,
  .CORE_NEG_TX_IN, .CORE_POS_RX_OUT, .POSITIVE_NAMED_PIN_IN, .NEGATIVE_NAMED_PIN_IN,
  .POSITIVE_NAMED_PIN_OUT, .NEGATIVE_NAMED_PIN_OUT, .PHYS1_LOGICAL_OUT, .PHYS2_LOGICAL_OUT,
  .DS_PORT_COUNT_OUT);
`default_nettype wire
